//--- design/mcio_pkg.sv
// Package of constants and types for the measurement control I/O block
package mcio_pkg;

  // ==========================================================
  // Register map (offsets are word addresses)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFS_MEAS = 4'h4;
  localparam logic [3:0] OFS_LIMIT_BASE = 4'h8;
  localparam logic [3:0] OFS_PROG_VALID = 4'h5;
  localparam logic [3:0] OFS_ERRWORD = 4'h6;

  // ==========================================================
  // Control register fields
  localparam int CTRL_EXPANSION_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_TOO_LITTLE_LIGHT_BIT = 8;
  localparam int CTRL_TOO_MUCH_LIGHT_BIT = 9;
  localparam int CTRL_NEAR_BIT = 10;
  localparam int CTRL_FAR_BIT = 11;

  // ==========================================================
  // Interrupt event bits
  localparam int EV_FUNC = 0;
  localparam int EV_ZERO_SET = 1;
  localparam int EV_ZERO_CLR = 2;
  localparam int EV_HOLD = 3;
  localparam int EV_PROG = 4;
  localparam int EV_WIDTH = 5;

  // ==========================================================
  // Sizes, timing and resets
  localparam int NUM_PROG = 5;
  localparam int NUM_MODES = 4;
  localparam int DEBOUNCE_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] LIMIT_UPPER_RESET = 32'h7FFFFFFF;
  localparam logic [31:0] LIMIT_LOWER_RESET = 32'h80000000;
  localparam logic [31:0] ERR_READ_DATA = 32'hDEADBEEF;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PEAK_TO_PEAK,
    MODE_PEAK,
    MODE_BOTTOM
  } meas_mode_t;

  typedef enum logic [1:0] {
    FUNC_DEFAULT,
    FUNC_FIRST_CHANNEL_ONLY,
    FUNC_SECOND_CHANNEL_ONLY
  } func_cfg_t;

  typedef struct packed {
    logic function_select_first;
    logic function_select_second;
    logic zero_set;
    logic zero_clear;
    logic freeze;
    logic [NUM_PROG-1:0] prog_select;
  } ctrl_inputs_t;

  typedef struct packed {
    logic light_alarm;
    logic range_exceeded_close_side;
    logic range_exceeded_distant_side;
    logic pass;
    logic over_limit;
    logic under_limit;
  } judge_outputs_t;

endpackage

//--- design/measurement_control_io.sv
// Discrete control inputs and judgment outputs of the displacement controller
// Behaviour
// RQ1: A control input is asserted while pulled to ground; low level means active.
// RQ2: Light alarm output is off when too too_little_light or too too_much_light, on otherwise.
// RQ3: Near-side range-exceeded output is on while target is outside range nearby.
// RQ4: Far-side range-exceeded output is on while target is outside range far away.
// RQ5: Pass output is on only while measurement lies within lower and upper limit.
// RQ6: Over-limit output is on while measurement exceeds the upper limit.
// RQ7: Under-limit output is on while measurement is below the lower limit.
// RQ8: First function select switches calculation to first-channel-only.
// RQ9: Second function select switches calculation to second-channel-only.
// RQ10: Function selects are ignored unless the expansion board is fitted.
// RQ11: Zero-reference input turns zero on, capturing present measurement as zero.
// RQ12: Zero-reference clear input cancels the active zero-reference state.
// RQ13: Hold is on while the freeze input is asserted, retaining measured value.
// RQ14: Five program selects; select n loads stored program n.
// RQ15: Selecting an empty program slot restores default measurement settings.
// RQ16: Separate limit pair per measurement mode; judgment uses active mode's pair.
// RQ17: Every control input is synchronised and debounced before use.
// RQ18: Program and zero inputs act on asserting edge; lowest program wins. Zero clear acts on its asserted level.
`timescale 1ns/1ps

module measurement_control_io (
  input wire logic sys_clk_in, // System clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic [3:0] avs_address_in, // Avalon word address
  input wire logic avs_read_in, // Avalon read request
  input wire logic avs_write_in, // Avalon write request
  input wire logic [31:0] avs_writedata_in, // Avalon write data
  output logic [31:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  input wire logic function_select_first_n_in, // Pin, low asserts
  input wire logic function_select_second_n_in, // Pin, low asserts
  input wire logic zero_set_n_in, // Pin, low asserts
  input wire logic zero_clear_n_in, // Pin, low asserts
  input wire logic freeze_n_in, // Pin, low asserts
  input wire logic [4:0] prog_select_n_in, // Pins, low asserts
  output logic light_alarm_out, // Light level alarm, high is on
  output logic range_exceeded_close_side_out, // Near-side out of range
  output logic range_exceeded_distant_side_out, // Far-side out of range
  output logic pass_out, // Within limits
  output logic over_limit_out, // Above upper limit
  output logic under_limit_out, // Below lower limit
  output logic [1:0] func_cfg_out, // Active calculation function
  output logic zero_active_out, // Zero reference on
  output logic [31:0] zero_value_out, // Captured zero
  output logic hold_active_out, // Hold function on
  output logic [31:0] held_value_out, // Held measurement
  output logic [2:0] prog_number_out, // Loaded program, 0 none
  output logic irq_out // Level interrupt
);

  localparam int NIN = 5 + mcio_pkg::NUM_PROG;

  // ==========================================================
  // Input synchronisers and debouncers
  logic [NIN-1:0] raw_act;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] stable_q;
  logic [NIN-1:0] stable_prev_q;
  logic [15:0] db_cnt_q [NIN];
  mcio_pkg::ctrl_inputs_t ctl;
  mcio_pkg::ctrl_inputs_t ctl_rise;

  // Pins are active low: invert to active high
  assign raw_act = ~{function_select_first_n_in, function_select_second_n_in, zero_set_n_in,
                     zero_clear_n_in, freeze_n_in, prog_select_n_in}; // RQ1

  // Two-flop synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_act;
      sync2_q <= sync1_q;
    end
  end

  // Accept a level only after it stays unchanged for the debounce time
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stable_q <= '0;
      stable_prev_q <= '0;
      for (int i = 0; i < NIN; i++) begin
        db_cnt_q[i] <= '0;
      end
    end else begin
      stable_prev_q <= stable_q;
      for (int i = 0; i < NIN; i++) begin
        if (sync2_q[i] == stable_q[i]) begin
          db_cnt_q[i] <= '0;
        end else if (db_cnt_q[i] == 16'(mcio_pkg::DEBOUNCE_CYCLES - 1)) begin
          db_cnt_q[i] <= '0;
          stable_q[i] <= sync2_q[i]; // RQ17
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  assign ctl = stable_q;
  assign ctl_rise = stable_q & ~stable_prev_q; // RQ18

  // ==========================================================
  // Register state
  logic expansion_q;
  mcio_pkg::meas_mode_t mode_q;
  logic too_little_light_q;
  logic too_much_light_q;
  logic near_q;
  logic far_q;
  logic [31:0] meas_q;
  logic [31:0] upper_q [mcio_pkg::NUM_MODES];
  logic [31:0] lower_q [mcio_pkg::NUM_MODES];
  logic [mcio_pkg::NUM_PROG-1:0] prog_valid_q;
  logic [mcio_pkg::EV_WIDTH-1:0] irq_status_q;
  logic [mcio_pkg::EV_WIDTH-1:0] irq_mask_q;
  logic [mcio_pkg::EV_WIDTH-1:0] events;
  logic wr;
  logic rd;
  logic rd_ack_q;
  logic prog_load;
  logic prog_empty;
  logic [2:0] prog_pick;

  assign wr = avs_write_in;
  assign rd = avs_read_in;
  // Reads wait one cycle for the registered read data; writes never wait
  assign avs_waitrequest_out = rd && !rd_ack_q;

  // Lowest numbered asserting program select wins
  function automatic logic [2:0] lowest_prog(input logic [mcio_pkg::NUM_PROG-1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    for (int i = mcio_pkg::NUM_PROG - 1; i >= 0; i--) begin
      if (sel[i]) begin
        r = 3'(i + 1);
      end
    end
    return r;
  endfunction

  // Program select bit 0 is pin of program 5 after concatenation, so reverse
  logic [mcio_pkg::NUM_PROG-1:0] prog_rise;
  always_comb begin
    for (int i = 0; i < mcio_pkg::NUM_PROG; i++) begin
      prog_rise[i] = ctl_rise.prog_select[mcio_pkg::NUM_PROG - 1 - i];
    end
  end

  assign prog_pick = lowest_prog(prog_rise); // RQ14 RQ18
  assign prog_load = (prog_pick != 3'h0);
  assign prog_empty = prog_load && !prog_valid_q[prog_pick - 3'h1];

  // Configuration written by software, with empty-slot default restore
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      expansion_q <= 1'b0;
      mode_q <= mcio_pkg::MODE_NORMAL;
      too_little_light_q <= 1'b0;
      too_much_light_q <= 1'b0;
      near_q <= 1'b0;
      far_q <= 1'b0;
      meas_q <= '0;
      prog_valid_q <= '0;
      for (int m = 0; m < mcio_pkg::NUM_MODES; m++) begin
        upper_q[m] <= mcio_pkg::LIMIT_UPPER_RESET;
        lower_q[m] <= mcio_pkg::LIMIT_LOWER_RESET;
      end
    end else begin
      // Restore first, so that an accepted write in the same cycle is not lost
      if (prog_empty) begin
        mode_q <= mcio_pkg::MODE_NORMAL; // RQ15
        for (int m = 0; m < mcio_pkg::NUM_MODES; m++) begin
          upper_q[m] <= mcio_pkg::LIMIT_UPPER_RESET;
          lower_q[m] <= mcio_pkg::LIMIT_LOWER_RESET;
        end
      end
      if (wr) begin
        case (avs_address_in)
          mcio_pkg::OFS_CTRL: begin
            expansion_q <= avs_writedata_in[mcio_pkg::CTRL_EXPANSION_BIT];
            mode_q <= mcio_pkg::meas_mode_t'(avs_writedata_in[mcio_pkg::CTRL_MODE_LSB +: 2]);
            too_little_light_q <= avs_writedata_in[mcio_pkg::CTRL_TOO_LITTLE_LIGHT_BIT];
            too_much_light_q <= avs_writedata_in[mcio_pkg::CTRL_TOO_MUCH_LIGHT_BIT];
            near_q <= avs_writedata_in[mcio_pkg::CTRL_NEAR_BIT];
            far_q <= avs_writedata_in[mcio_pkg::CTRL_FAR_BIT];
          end
          mcio_pkg::OFS_MEAS: meas_q <= avs_writedata_in;
          mcio_pkg::OFS_PROG_VALID: prog_valid_q <= avs_writedata_in[mcio_pkg::NUM_PROG-1:0];
          default: begin
            if (avs_address_in >= mcio_pkg::OFS_LIMIT_BASE) begin
              if (avs_address_in[0]) begin
                lower_q[avs_address_in[2:1]] <= avs_writedata_in; // RQ16
              end else begin
                upper_q[avs_address_in[2:1]] <= avs_writedata_in; // RQ16
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Function, zero, hold and program state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      func_cfg_out <= 2'(mcio_pkg::FUNC_DEFAULT);
    end else if (expansion_q) begin // RQ10
      if (ctl.function_select_first) begin
        func_cfg_out <= 2'(mcio_pkg::FUNC_FIRST_CHANNEL_ONLY); // RQ8
      end else if (ctl.function_select_second) begin
        func_cfg_out <= 2'(mcio_pkg::FUNC_SECOND_CHANNEL_ONLY); // RQ9
      end
    end
  end

  // Zero reference: set on asserting edge, clear cancels
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      zero_active_out <= 1'b0;
      zero_value_out <= '0;
    end else if (ctl_rise.zero_set) begin
      zero_active_out <= 1'b1; // RQ11
      zero_value_out <= meas_q; // RQ11
    end else if (ctl.zero_clear) begin
      zero_active_out <= 1'b0; // RQ12
    end
  end

  // Hold retains the value seen when freeze took effect
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hold_active_out <= 1'b0;
      held_value_out <= '0;
    end else begin
      hold_active_out <= ctl.freeze; // RQ13
      if (!ctl.freeze) begin
        held_value_out <= meas_q; // RQ13
      end
    end
  end

  // Loaded program number
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prog_number_out <= 3'h0;
    end else if (prog_load) begin
      prog_number_out <= prog_pick; // RQ14
    end
  end

  // ==========================================================
  // Judgment outputs
  logic signed [31:0] cur;
  logic signed [31:0] up;
  logic signed [31:0] lo;
  assign cur = hold_active_out ? held_value_out : meas_q;
  assign up = upper_q[mode_q]; // RQ16
  assign lo = lower_q[mode_q]; // RQ16

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      light_alarm_out <= 1'b0;
      range_exceeded_close_side_out <= 1'b0;
      range_exceeded_distant_side_out <= 1'b0;
      pass_out <= 1'b0;
      over_limit_out <= 1'b0;
      under_limit_out <= 1'b0;
    end else begin
      light_alarm_out <= !(too_little_light_q || too_much_light_q); // RQ2
      range_exceeded_close_side_out <= near_q; // RQ3
      range_exceeded_distant_side_out <= far_q; // RQ4
      pass_out <= (cur >= lo) && (cur <= up); // RQ5
      over_limit_out <= cur > up; // RQ6
      under_limit_out <= cur < lo; // RQ7
    end
  end

  // ==========================================================
  // Interrupt status, set wins over write-one-to-clear
  assign events = {prog_load, ctl_rise.freeze, ctl_rise.zero_clear, ctl_rise.zero_set,
                   expansion_q & (ctl_rise.function_select_first | ctl_rise.function_select_second)};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr && avs_address_in == mcio_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= avs_writedata_in[mcio_pkg::EV_WIDTH-1:0];
      end
      if (wr && avs_address_in == mcio_pkg::OFS_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~avs_writedata_in[mcio_pkg::EV_WIDTH-1:0]) | events;
      end else begin
        irq_status_q <= irq_status_q | events;
      end
    end
  end

  assign irq_out = |(irq_status_q & irq_mask_q);

  // ==========================================================
  // Read data, registered, standing at the edge where waitrequest is low
  logic [31:0] rdata;
  always_comb begin
    rdata = mcio_pkg::ERR_READ_DATA;
    case (avs_address_in)
      mcio_pkg::OFS_CTRL: begin
        rdata = '0;
        rdata[mcio_pkg::CTRL_EXPANSION_BIT] = expansion_q;
        rdata[mcio_pkg::CTRL_MODE_LSB +: 2] = mode_q;
        rdata[mcio_pkg::CTRL_TOO_LITTLE_LIGHT_BIT] = too_little_light_q;
        rdata[mcio_pkg::CTRL_TOO_MUCH_LIGHT_BIT] = too_much_light_q;
        rdata[mcio_pkg::CTRL_NEAR_BIT] = near_q;
        rdata[mcio_pkg::CTRL_FAR_BIT] = far_q;
      end
      mcio_pkg::OFS_STATUS: rdata = {16'h0000, 3'h0, stable_q[4:0], prog_number_out, hold_active_out,
                                     zero_active_out, func_cfg_out, pass_out};
      mcio_pkg::OFS_IRQ_STATUS: rdata = {27'h0000000, irq_status_q};
      mcio_pkg::OFS_IRQ_MASK: rdata = {27'h0000000, irq_mask_q};
      mcio_pkg::OFS_MEAS: rdata = meas_q;
      mcio_pkg::OFS_PROG_VALID: rdata = {27'h0000000, prog_valid_q};
      default: begin
        if (avs_address_in >= mcio_pkg::OFS_LIMIT_BASE) begin
          rdata = avs_address_in[0] ? lower_q[avs_address_in[2:1]] : upper_q[avs_address_in[2:1]];
        end
      end
    endcase
  end

  // First read cycle loads the data and stalls; the second cycle completes it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_ack_q <= 1'b0;
      avs_readdata_out <= '0;
    end else begin
      rd_ack_q <= rd && !rd_ack_q;
      if (rd && !rd_ack_q) begin
        avs_readdata_out <= rdata;
      end
    end
  end

endmodule // measurement_control_io

//--- tb/ext_controller.sv
// External controller model that closes control contacts to ground
`timescale 1ns/1ps
module ext_controller (
  input wire mcio_pkg::ctrl_inputs_t close_in, // Contacts to close
  output logic [9:0] pin_out // Pin levels, pulled up when open
);
  // An open contact floats to the pull-up, a closed one sinks to ground
  assign pin_out = ~close_in;
endmodule // ext_controller

//--- tb/mcio_checker.sv
// Checker of the pin and judgment behaviour of the control I/O block
`timescale 1ns/1ps
module mcio_checker (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic [3:0] avs_address_in, // Address
  input wire logic avs_write_in, // Write
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic avs_waitrequest_out, // Wait
  input wire logic zero_set_n_in, // Pin
  input wire logic zero_clear_n_in, // Pin
  input wire logic freeze_n_in, // Pin
  input wire logic light_alarm_out, // Out
  input wire logic range_exceeded_close_side_out, // Out
  input wire logic range_exceeded_distant_side_out, // Out
  input wire logic pass_out, // Out
  input wire logic over_limit_out, // Out
  input wire logic under_limit_out, // Out
  input wire logic [1:0] func_cfg_out, // Out
  input wire logic zero_active_out, // Out
  input wire logic hold_active_out, // Out
  input wire logic [2:0] prog_number_out // Out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] zs_q, zc_q, fl_q, fh_q;
  logic wr_ctrl;
  // Accepted write to the control register
  assign wr_ctrl = avs_write_in && !avs_waitrequest_out && avs_address_in == mcio_pkg::OFS_CTRL;
  // Saturating counts of how long each pin has held its level
  always_ff @(posedge sys_clk_in) begin
    zs_q <= (rst_in || zero_set_n_in) ? 8'h00 : zs_q + {7'h00, zs_q != 8'hFF};
    zc_q <= (rst_in || zero_clear_n_in) ? 8'h00 : zc_q + {7'h00, zc_q != 8'hFF};
    fl_q <= (rst_in || freeze_n_in) ? 8'h00 : fl_q + {7'h00, fl_q != 8'hFF};
    fh_q <= (rst_in || !freeze_n_in) ? 8'h00 : fh_q + {7'h00, fh_q != 8'hFF};
  end
  a_light_alarm_off: assert property (wr_ctrl && (avs_writedata_in[8] || avs_writedata_in[9])
    |-> ##[1:3] !light_alarm_out) else $error("light alarm stayed on");
  a_near_flag_on: assert property (wr_ctrl && avs_writedata_in[10]
    |-> ##[1:3] range_exceeded_close_side_out) else $error("near flag not set");
  a_far_flag_on: assert property (wr_ctrl && avs_writedata_in[11]
    |-> ##[1:3] range_exceeded_distant_side_out) else $error("far flag not set");
  a_judge_exclusive: assert property ($onehot0({pass_out, over_limit_out, under_limit_out}))
    else $error("judgment outputs overlap");
  a_func_legal: assert property (func_cfg_out != 2'h3)
    else $error("illegal function");
  a_zero_debounced: assert property ($rose(zero_active_out) |-> zs_q >= 8'h64)
    else $error("zero set before debounce");
  a_zero_cancel_debounced: assert property ($fell(zero_active_out) |-> zc_q >= 8'h64)
    else $error("zero cleared without clear pin");
  a_hold_follows_pin: assert property (fl_q == 8'h6E |-> hold_active_out)
    else $error("hold not on");
  a_hold_released: assert property (fh_q == 8'h6E |-> !hold_active_out)
    else $error("hold not off");
  a_prog_in_range: assert property (prog_number_out <= 3'h5)
    else $error("program number out of range");
endmodule // mcio_checker
bind measurement_control_io mcio_checker chk (.sys_clk_in, .rst_in, .avs_address_in, .avs_write_in,
  .avs_writedata_in, .avs_waitrequest_out, .zero_set_n_in, .zero_clear_n_in, .freeze_n_in, .light_alarm_out,
  .range_exceeded_close_side_out, .range_exceeded_distant_side_out, .pass_out, .over_limit_out,
  .under_limit_out, .func_cfg_out, .zero_active_out, .hold_active_out, .prog_number_out);

//--- tb/testbench.sv
// Self-checking testbench of the control I/O block
`timescale 1ns/1ps
module testbench;
  logic clk, rst, rd_r, wr_r, wt, alm, nr, fr, ps, ov, un, za, ha, irq;
  logic [3:0] adr;
  logic [31:0] wd, rdat, zv, hv, d;
  logic [1:0] fc;
  logic [2:0] pn;
  logic [9:0] pins;
  mcio_pkg::ctrl_inputs_t cmd;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ext_controller ctl (.close_in(cmd), .pin_out(pins));
  measurement_control_io dut (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd_r),
    .avs_write_in(wr_r), .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .function_select_first_n_in(pins[9]), .function_select_second_n_in(pins[8]), .zero_set_n_in(pins[7]),
    .zero_clear_n_in(pins[6]), .freeze_n_in(pins[5]), .prog_select_n_in(pins[4:0]), .light_alarm_out(alm),
    .range_exceeded_close_side_out(nr), .range_exceeded_distant_side_out(fr), .pass_out(ps),
    .over_limit_out(ov), .under_limit_out(un), .func_cfg_out(fc), .zero_active_out(za), .zero_value_out(zv),
    .hold_active_out(ha), .held_value_out(hv), .prog_number_out(pn), .irq_out(irq));
  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask
  // ==========================================================
  // Bus cycles and pin settling
  task automatic bw(input logic [3:0] a, input logic [31:0] v);
    adr <= a;
    wd <= v;
    wr_r <= 1'b1;
    do @(posedge clk); while (wt !== 1'b0);
    wr_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic br(input logic [3:0] a);
    adr <= a;
    rd_r <= 1'b1;
    do @(posedge clk); while (wt !== 1'b0);
    d = rdat;
    rd_r <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_flags();
    for (int i = 8; i < 13; i++) begin
      bw(mcio_pkg::OFS_CTRL, 32'h1 << i);
      settle(3);
      cmp_bit(alm, !(i == 8 || i == 9));
      cmp_bit(nr, i == 10);
      cmp_bit(fr, i == 11);
    end
  endtask
  task automatic judge(input logic [31:0] m, input logic [2:0] e);
    bw(mcio_pkg::OFS_MEAS, m);
    settle(3);
    cmp_word({29'h0, ps, ov, un}, {29'h0, e});
  endtask
  task automatic t_judge();
    bw(4'h8, 32'h64);
    bw(4'h9, 32'hFFFFFF9C);
    judge(32'h64, 3'h4);
    judge(32'h65, 3'h2);
    judge(32'hFFFFFF9C, 3'h4);
    judge(32'hFFFFFF9B, 3'h1);
    bw(mcio_pkg::OFS_CTRL, 32'h20);
    bw(4'hC, 32'hA);
    bw(4'hD, 32'h5);
    judge(32'h0, 3'h1);
    judge(32'h7, 3'h4);
  endtask
  task automatic t_func();
    bw(mcio_pkg::OFS_CTRL, 32'h0);
    cmd.function_select_first <= 1'b1;
    settle(150);
    cmp_word({30'h0, fc}, 32'h0);
    bw(mcio_pkg::OFS_CTRL, 32'h1);
    settle(150);
    cmp_word({30'h0, fc}, 32'h1);
    cmd.function_select_first <= 1'b0;
    cmd.function_select_second <= 1'b1;
    settle(150);
    cmp_word({30'h0, fc}, 32'h2);
    cmd.function_select_second <= 1'b0;
  endtask
  task automatic t_zero();
    bw(mcio_pkg::OFS_MEAS, 32'h55);
    bw(mcio_pkg::OFS_IRQ_MASK, 32'h2);
    cmd.zero_set <= 1'b1;
    settle(50);
    cmd.zero_set <= 1'b0;
    settle(150);
    cmp_bit(za, 1'b0);
    cmd.zero_set <= 1'b1;
    settle(150);
    cmp_bit(za, 1'b1);
    cmp_word(zv, 32'h55);
    cmp_bit(irq, 1'b1);
    cmd.zero_set <= 1'b0;
    bw(mcio_pkg::OFS_IRQ_STATUS, 32'h2);
    cmp_bit(irq, 1'b0);
    cmd.zero_clear <= 1'b1;
    settle(150);
    cmp_bit(za, 1'b0);
    cmp_bit(irq, 1'b0);
    br(mcio_pkg::OFS_IRQ_STATUS);
    cmp_word(d & 32'h4, 32'h4);
    cmd.zero_clear <= 1'b0;
  endtask
  task automatic t_hold();
    bw(mcio_pkg::OFS_MEAS, 32'h33);
    cmd.freeze <= 1'b1;
    settle(150);
    bw(mcio_pkg::OFS_MEAS, 32'h44);
    cmp_bit(ha, 1'b1);
    cmp_word(hv, 32'h33);
    cmd.freeze <= 1'b0;
    settle(150);
    cmp_bit(ha, 1'b0);
  endtask
  task automatic t_prog();
    bw(4'h8, 32'h5);
    bw(mcio_pkg::OFS_CTRL, 32'h30);
    for (int n = 1; n < 6; n++) begin
      cmd.prog_select <= 5'h10 >> (n - 1);
      settle(150);
      cmp_word({29'h0, pn}, n);
      cmd.prog_select <= 5'h00;
      settle(150);
    end
    br(4'h8);
    cmp_word(d, mcio_pkg::LIMIT_UPPER_RESET);
    br(mcio_pkg::OFS_CTRL);
    cmp_word(d & 32'h30, 32'h0);
    cmd.prog_select <= 5'h0A;
    settle(150);
    cmp_word({29'h0, pn}, 32'h2);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {rd_r, wr_r, adr, wd} = '0;
    cmd = '0;
    settle(6);
    rst <= 1'b0;
    settle(3);
    cmp_bit(alm, 1'b1);
    cmp_bit(ps, 1'b1);
    br(4'h7);
    cmp_word(d, mcio_pkg::ERR_READ_DATA);
    br(4'h9);
    cmp_word(d, mcio_pkg::LIMIT_LOWER_RESET);
    t_flags();
    t_judge();
    t_func();
    t_zero();
    t_hold();
    t_prog();
    give_verdict();
  end
endmodule // testbench
